/* logic/agc_loop.sv */
`timescale 1ns/1ns
module agc_loop import agc_pkg::*; #(
  parameter int SMP_W = 24
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [SMP_W-1:0] d1_i,
  input wire logic [SMP_W-1:0] d1_q,
  input wire logic d1_valid,
  input wire logic [SMP_W-1:0] dg_i,
  input wire logic [SMP_W-1:0] dg_q,
  input wire logic dg_valid,
  input wire logic adc_overload,
  input wire logic adc_reset,
  input wire logic out_strobe,
  output logic loop_tick,
  output logic [7:0] vga_dac_code,
  output logic dac_fast_acq,
  output logic mixer_extra_attenuation,
  output logic [13:0] dg_backoff,
  output logic [1:0] dg_shift,
  output logic [7:0] attenuation_report,
  output logic [5:0] strength,
  output logic [7:0] ovl_count,
  output logic [7:0] rst_count
);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------
  logic [7:0] reg03_q;
  logic [7:0] reg04_q;
  logic [7:0] reg05_q;
  logic [7:0] reg06_q;
  logic [14:0] gain_q;
  logic [14:0] gain_d;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg03_q <= AGC_REG_RST;
      reg04_q <= AGC_REG_RST;
      reg05_q <= AGC_REG_RST;
      reg06_q <= AGC_REG_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        AGC_ADDR_GAIN_HI: reg03_q <= reg_wdata;
        AGC_ADDR_GAIN_LO: reg04_q <= reg_wdata;
        AGC_ADDR_LOOP: reg05_q <= reg_wdata;
        AGC_ADDR_MODE: reg06_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Gain word reads back the live loop value
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        AGC_ADDR_GAIN_HI: reg_rdata <= {reg03_q[AGC_MIX_BIT], gain_q[14:8]};
        AGC_ADDR_GAIN_LO: reg_rdata <= gain_q[7:0];
        AGC_ADDR_LOOP: reg_rdata <= reg05_q;
        AGC_ADDR_MODE: reg_rdata <= reg06_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  logic [3:0] attack_code;
  logic [3:0] decay_code;
  logic digital_gain_enable;
  logic [2:0] reset_weight_code;
  logic [2:0] reference_level_select;
  logic auto_mode;
  logic [14:0] host_word;

  always_comb begin
    attack_code = reg05_q[7:4];
    decay_code = reg05_q[3:0];
    digital_gain_enable = reg06_q[AGC_DGEN_BIT];
    reset_weight_code = reg06_q[6:4];
    reference_level_select = reg06_q[2:0];
    auto_mode = (reference_level_select != 3'h0);
    host_word = {reg03_q[6:0], reg04_q};
  end

  assign dac_fast_acq = reg06_q[AGC_FAST_BIT];
  assign mixer_extra_attenuation = reg03_q[AGC_MIX_BIT];

  // ----------------------------------------------------------------
  // Loop tick divider
  // ----------------------------------------------------------------
  logic [5:0] div_q;
  logic tick;

  assign tick = (div_q == 6'(AGC_TICK_DIV - 1));
  assign loop_tick = tick;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 6'h00;
    end else if (tick) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Level estimators
  // ----------------------------------------------------------------
  logic [15:0] lvl_d1;
  logic [15:0] lvl_dg;
  logic [15:0] lvl;
  logic [15:0] ref_lvl;

  agc_lvl_est #(.SMP_W(SMP_W)) u_est_first (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .smp_i(d1_i),
    .smp_q(d1_q),
    .smp_valid(d1_valid),
    .tick(tick),
    .level_q(lvl_d1)
  );

  agc_lvl_est #(.SMP_W(SMP_W)) u_est_dgain (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .smp_i(dg_i),
    .smp_q(dg_q),
    .smp_valid(dg_valid),
    .tick(tick),
    .level_q(lvl_dg)
  );

  always_comb begin
    if (digital_gain_enable && (lvl_dg > lvl_d1)) begin
      lvl = lvl_dg;
    end else begin
      lvl = lvl_d1;
    end
    ref_lvl = agc_ref_level(reference_level_select);
  end

  // ----------------------------------------------------------------
  // ADC event synchronisers and per-period counters
  // ----------------------------------------------------------------
  logic [1:0] ev_s1_q;
  logic [1:0] ev_s2_q;
  logic [1:0] ev_s3_q;
  logic ovl_ev;
  logic rst_ev;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ev_s1_q <= 2'b00;
      ev_s2_q <= 2'b00;
      ev_s3_q <= 2'b00;
    end else begin
      ev_s1_q <= {adc_reset, adc_overload};
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end

  assign ovl_ev = ev_s2_q[0] & ~ev_s3_q[0];
  assign rst_ev = ev_s2_q[1] & ~ev_s3_q[1];

  function automatic logic [7:0] cnt_next(input logic [7:0] c, input logic ev,
                                          input logic restart);
    logic [7:0] base;
    base = restart ? 8'h00 : c;
    if (ev && base != AGC_CNT_MAX) begin
      return base + 8'h01;
    end
    return base;
  endfunction : cnt_next

  logic [7:0] ovl_run_q;
  logic [7:0] rst_run_q;

  // Event in the strobe cycle opens the next period, never lost
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ovl_run_q <= 8'h00;
      rst_run_q <= 8'h00;
      ovl_count <= 8'h00;
      rst_count <= 8'h00;
    end else begin
      ovl_run_q <= cnt_next(ovl_run_q, ovl_ev, out_strobe);
      rst_run_q <= cnt_next(rst_run_q, rst_ev, out_strobe);
      if (out_strobe) begin
        ovl_count <= ovl_run_q;
        rst_count <= rst_run_q;
      end
    end
  end

  // Reset events waiting for the next loop tick
  logic [3:0] pend_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 4'h0;
    end else if (tick) begin
      pend_q <= {3'h0, rst_ev};
    end else if (rst_ev && pend_q != AGC_PEND_MAX) begin
      pend_q <= pend_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Gain update
  // ----------------------------------------------------------------
  // Shift by k half-octaves: odd k adds a factor of about 1/root two
  function automatic logic [15:0] step_scale(input logic [15:0] d, input logic [5:0] k);
    logic [15:0] s;
    s = d >> k[5:1];
    if (k[0]) begin
      s = s - (s >> 2) - (s >> 5) - (s >> 6);
    end
    return s;
  endfunction : step_scale

  logic [5:0] k_att;
  logic [5:0] k_dec;
  logic [15:0] err;
  logic lvl_high;
  logic [17:0] up_step;
  logic [17:0] dn_step;
  logic [17:0] rst_add;
  logic [17:0] sum;
  logic [17:0] net;
  logic [14:0] lim;

  always_comb begin
    k_att = AGC_LOOP_BASE_K + {2'b00, 4'hF - attack_code};
    k_dec = k_att + {2'b00, decay_code};
    lvl_high = (lvl > ref_lvl);
    err = lvl_high ? (lvl - ref_lvl) : (ref_lvl - lvl);
    up_step = lvl_high ? {2'b00, step_scale(err, k_att)} : 18'h00000;
    dn_step = lvl_high ? 18'h00000 : {2'b00, step_scale(err, k_dec)};
    rst_add = (AGC_RST_W_BASE << reset_weight_code) * {14'h0000, pend_q};
    lim = digital_gain_enable ? AGC_GAIN_MAX_DG : AGC_GAIN_MAX;
    sum = {3'b000, gain_q} + up_step + rst_add;
    net = (sum < dn_step) ? 18'h00000 : (sum - dn_step);
    if (!auto_mode) begin
      gain_d = host_word;
    end else if (tick) begin
      gain_d = (net > {3'b000, lim}) ? lim : net[14:0];
    end else begin
      gain_d = gain_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gain_q <= 15'h0000;
    end else begin
      gain_q <= gain_d;
    end
  end

  // ----------------------------------------------------------------
  // Split of the gain word between analog and digital paths
  // ----------------------------------------------------------------
  logic [13:0] ana_att;
  logic [13:0] dig_back;
  logic [21:0] rssi_prod;

  always_comb begin
    if (!digital_gain_enable) begin
      ana_att = gain_q[13:0];
      dig_back = AGC_BACKOFF_UNITY;
    end else if (gain_q >= AGC_DG_UNITY) begin
      ana_att = gain_q[13:0];
      dig_back = AGC_BACKOFF_UNITY;
    end else begin
      ana_att = 14'h0000;
      dig_back = gain_q[13:0];
    end
    rssi_prod = lvl * {10'h000, AGC_RSSI_FS};
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      vga_dac_code <= 8'h00;
      dg_backoff <= AGC_BACKOFF_UNITY;
      dg_shift <= 2'h0;
      attenuation_report <= 8'h00;
    end else begin
      vga_dac_code <= ana_att[13:6];
      dg_backoff <= dig_back;
      if (dig_back < AGC_SHIFT1_AT) begin
        dg_shift <= 2'h2;
      end else if (dig_back < AGC_SHIFT0_AT) begin
        dg_shift <= 2'h1;
      end else begin
        dg_shift <= 2'h0;
      end
      attenuation_report <= {reg03_q[AGC_MIX_BIT], gain_q[14:8]};
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      strength <= 6'h00;
    end else if (tick) begin
      strength <= rssi_prod[21:16];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  tick_period_a: assert property (tick |-> ##60 tick)
    else $error("loop tick period is not 60");
  gain_hold_a: assert property (auto_mode && !tick |=> $stable(gain_q))
    else $error("gain moved between ticks");
  manual_gain_a: assert property (!auto_mode |=> gain_q == $past(host_word))
    else $error("manual gain not from host word");
  attack_up_a: assert property (tick && auto_mode && lvl_high && gain_q < lim
    |=> gain_q >= $past(gain_q)) else $error("attenuation fell on high level");
  decay_dn_a: assert property (tick && auto_mode && !lvl_high && pend_q == 4'h0
    |=> gain_q <= $past(gain_q)) else $error("attenuation rose on low level");
  gain_sat_a: assert property (tick && auto_mode |=> gain_q <= $past(lim))
    else $error("gain beyond limit");
  report_msb_a: assert property (##1 attenuation_report[6:0] == $past(gain_q[14:8]))
    else $error("report not gain MSBs");
  unity_dg_a: assert property (!digital_gain_enable |=> dg_shift == 2'h0)
    else $error("digital gain active while disabled");
  analog_idle_a: assert property (digital_gain_enable && gain_q < AGC_DG_UNITY
    |=> vga_dac_code == 8'h00) else $error("analog attenuation above unity gain");

endmodule : agc_loop

/* logic/agc_lvl_est.sv */
`timescale 1ns/1ns
module agc_lvl_est #(
  parameter int SMP_W = 24
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [SMP_W-1:0] smp_i,
  input wire logic [SMP_W-1:0] smp_q,
  input wire logic smp_valid,
  input wire logic tick,
  output logic [15:0] level_q
);

  logic [SMP_W-1:0] abs_i;
  logic [SMP_W-1:0] abs_q;
  logic [SMP_W:0] sum;
  logic [15:0] cur;
  logic [15:0] peak_q;
  logic [15:0] peak_now;

  // ----------------------------------------------------------------
  // Magnitude estimate |I| + |Q|
  // ----------------------------------------------------------------
  always_comb begin
    abs_i = smp_i[SMP_W-1] ? (~smp_i + 1'b1) : smp_i;
    abs_q = smp_q[SMP_W-1] ? (~smp_q + 1'b1) : smp_q;
    sum = {1'b0, abs_i} + {1'b0, abs_q};
    cur = smp_valid ? sum[SMP_W -: 16] : 16'h0000;
    peak_now = (cur > peak_q) ? cur : peak_q;
  end

  // ----------------------------------------------------------------
  // Peak over one loop period, published on the tick
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      peak_q <= 16'h0000;
    end else if (tick) begin
      peak_q <= 16'h0000;
    end else begin
      peak_q <= peak_now;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      level_q <= 16'h0000;
    end else if (tick) begin
      level_q <= peak_now;
    end
  end

  peak_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    tick |=> level_q >= $past(cur)) else $error("level below current sample");

endmodule : agc_lvl_est

/* logic/agc_pkg.sv */
package agc_pkg;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] AGC_ADDR_GAIN_HI = 8'h03;
  localparam logic [7:0] AGC_ADDR_GAIN_LO = 8'h04;
  localparam logic [7:0] AGC_ADDR_LOOP = 8'h05;
  localparam logic [7:0] AGC_ADDR_MODE = 8'h06;
  localparam logic [7:0] AGC_REG_RST = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AGC_MIX_BIT = 7;
  localparam int AGC_DGEN_BIT = 7;
  localparam int AGC_FAST_BIT = 3;

  // ----------------------------------------------------------------
  // Loop timing and gain ranges
  // ----------------------------------------------------------------
  localparam int AGC_TICK_DIV = 60;
  localparam logic [14:0] AGC_GAIN_MAX = 15'h3FFF;
  localparam logic [14:0] AGC_GAIN_MAX_DG = 15'h7FFF;
  localparam logic [14:0] AGC_DG_UNITY = 15'h4000;
  localparam logic [13:0] AGC_BACKOFF_UNITY = 14'h3FFF;
  localparam logic [13:0] AGC_SHIFT1_AT = 14'h1555;
  localparam logic [13:0] AGC_SHIFT0_AT = 14'h2AAA;
  localparam logic [5:0] AGC_LOOP_BASE_K = 6'h04;
  localparam logic [17:0] AGC_RST_W_BASE = 18'h00008;
  localparam logic [5:0] AGC_RSSI_FS = 6'h3C;
  localparam logic [3:0] AGC_PEND_MAX = 4'hF;
  localparam logic [7:0] AGC_CNT_MAX = 8'hFF;

  // Target levels on the 16-bit estimate scale, 1 = clip 5 dB under full scale
  function automatic logic [15:0] agc_ref_level(input logic [2:0] sel);
    unique case (sel)
      3'h1: return 16'h8FF3;
      3'h2: return 16'h65EA;
      3'h3: return 16'h4825;
      3'h4: return 16'h3314;
      default: return 16'h2428;
    endcase
  endfunction : agc_ref_level

endpackage : agc_pkg

/* test/agc_fe_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Converter front end: decimated I/Q samples at a commanded amplitude
// ----------------------------------------------------------------
module agc_fe_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic [23:0] amp,
  output logic [23:0] d1_i,
  output logic [23:0] d1_q,
  output logic d1_valid,
  output logic [23:0] dg_i,
  output logic [23:0] dg_q,
  output logic dg_valid
);
  logic [3:0] cnt_q;
  logic neg_q;
  logic [23:0] s1;
  logic [23:0] s2;

  // Sample spacing stays short, so wide attack codes remain usable
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      neg_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (d1_valid) begin
        neg_q <= ~neg_q;
      end
    end
  end

  assign d1_valid = slow ? (cnt_q == 4'hF) : (cnt_q[1:0] == 2'h3);
  assign dg_valid = d1_valid;
  assign s1 = neg_q ? -amp : amp;
  assign s2 = {1'b0, amp[23:1]};
  // Outside a strobe the lines carry junk, not the last sample
  assign d1_i = d1_valid ? s1 : ~s1;
  assign d1_q = d1_valid ? -s1 : s1;
  assign dg_i = dg_valid ? s2 : ~s2;
  assign dg_q = dg_valid ? -s2 : s2;
endmodule : agc_fe_model

/* test/tb_automatic_gain_control_loop.sv */
`timescale 1ns/1ns
module tb_automatic_gain_control_loop import agc_pkg::*;;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] vga;
    logic [13:0] bo;
    logic [1:0] sh;
  } agc_row_t;

  logic sys_clk, rstn, reg_wr, d1_valid, dg_valid, adc_overload, adc_reset, out_strobe;
  logic loop_tick, dac_fast_acq, mixer_extra_attenuation, slow;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, vga_dac_code, attenuation_report;
  logic [7:0] ovl_count, rst_count, h, l;
  logic [23:0] d1_i, d1_q, dg_i, dg_q, amp;
  logic [13:0] dg_backoff;
  logic [1:0] dg_shift;
  logic [5:0] strength;
  logic [14:0] g;
  int err_total, n_compared, n;
  agc_row_t rows [6] = '{
    {8'h00, 8'h85, 8'h5A, 8'h15, 14'h3FFF, 2'h0},
    {8'h00, 8'h3F, 8'hFF, 8'hFF, 14'h3FFF, 2'h0},
    {8'h80, 8'h00, 8'h00, 8'h00, 14'h0000, 2'h2},
    {8'h80, 8'h20, 8'h00, 8'h00, 14'h2000, 2'h1},
    {8'h80, 8'hC1, 8'h00, 8'h04, 14'h3FFF, 2'h0},
    {8'h88, 8'h7F, 8'hFF, 8'hFF, 14'h3FFF, 2'h0}};
  logic [7:0] st_mode [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h05};
  logic [7:0] st_att [6] = '{8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hD0};
  logic [14:0] st_exp [6] = '{15'h0000, 15'h0000, 15'h0000, 15'h033B, 15'h06F6, 15'h037B};

  agc_loop #(.SMP_W(24)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .d1_i(d1_i), .d1_q(d1_q),
    .d1_valid(d1_valid), .dg_i(dg_i), .dg_q(dg_q), .dg_valid(dg_valid),
    .adc_overload(adc_overload), .adc_reset(adc_reset), .out_strobe(out_strobe),
    .loop_tick(loop_tick), .vga_dac_code(vga_dac_code), .dac_fast_acq(dac_fast_acq),
    .mixer_extra_attenuation(mixer_extra_attenuation), .dg_backoff(dg_backoff),
    .dg_shift(dg_shift), .attenuation_report(attenuation_report), .strength(strength),
    .ovl_count(ovl_count), .rst_count(rst_count));

  agc_fe_model fe (
    .sys_clk(sys_clk), .rstn(rstn), .slow(slow), .amp(amp), .d1_i(d1_i), .d1_q(d1_q),
    .d1_valid(d1_valid), .dg_i(dg_i), .dg_q(dg_q), .dg_valid(dg_valid));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("Compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic cyc(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    cyc(1);
    d = reg_rdata;
  endtask : rd

  task automatic wait_tick();
    int i;
    cyc(1);
    for (i = 0; i < 70 && loop_tick !== 1'b1; i++) cyc(1);
    if (loop_tick !== 1'b1) begin
      err_total++;
      $display("Error loop_tick expected 1 seen %b", loop_tick);
      print_verdict();
    end
  endtask : wait_tick

  task automatic do_reset();
    rstn = 1'b0;
    cyc(3);
    rstn = 1'b1;
  endtask : do_reset

  task automatic pulse(ref logic s, input int k);
    repeat (k) begin
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(2);
    end
  endtask : pulse

  // Fresh reset, arm the loop right after a tick, read the gain after the next tick
  task automatic first_step(input logic [7:0] mode, input logic [7:0] loopv, input bit ev);
    do_reset();
    wait_tick();
    wait_tick();
    wr(AGC_ADDR_LOOP, loopv);
    wr(AGC_ADDR_MODE, mode);
    if (ev) begin
      pulse(adc_reset, 1);
      pulse(adc_overload, 2);
    end
    wait_tick();
    cyc(1);
    rd(AGC_ADDR_GAIN_HI, h);
    rd(AGC_ADDR_GAIN_LO, l);
    g = {h[6:0], l};
  endtask : first_step

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, reg_wr, adc_overload, adc_reset, out_strobe, slow} = 6'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    amp = 24'h400000;
    err_total = 0;
    n_compared = 0;
    do_reset();
    n = 0;
    while (loop_tick !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    cmp("first_tick", 16'h003B, n[15:0]);
    cyc(1);
    n = 1;
    while (loop_tick !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    cmp("tick_period", 16'h003C, n[15:0]);
    for (int a = 3; a < 8; a++) begin
      rd(a[7:0], h);
      cmp("reset_reg", 16'h0000, {8'h00, h});
    end
    cmp("reset_backoff", 16'h3FFF, {2'h0, dg_backoff});
    wr(8'h07, 8'h55);
    wr(AGC_ADDR_LOOP, 8'hA3);
    rd(AGC_ADDR_LOOP, h);
    cmp("loop_reg", 16'h00A3, {8'h00, h});
    // Manual gain word, digital gain off and on
    foreach (rows[r]) begin
      wr(AGC_ADDR_MODE, rows[r].mode);
      wr(AGC_ADDR_GAIN_HI, rows[r].hi);
      cyc(240);
      wr(AGC_ADDR_GAIN_LO, rows[r].lo);
      cyc(240);
      rd(AGC_ADDR_GAIN_HI, h);
      cmp("gain_hi", {8'h00, rows[r].hi}, {8'h00, h});
      rd(AGC_ADDR_GAIN_LO, l);
      cmp("gain_lo", {8'h00, rows[r].lo}, {8'h00, l});
      rd(AGC_ADDR_MODE, h);
      cmp("mode", {8'h00, rows[r].mode}, {8'h00, h});
      cmp("vga", {8'h00, rows[r].vga}, {8'h00, vga_dac_code});
      cmp("backoff", {2'h0, rows[r].bo}, {2'h0, dg_backoff});
      cmp("shift", {14'h0, rows[r].sh}, {14'h0, dg_shift});
      cmp("report", {8'h00, rows[r].hi}, {8'h00, attenuation_report});
      cmp("mixer", {15'h0, rows[r].hi[7]}, {15'h0, mixer_extra_attenuation});
      cmp("fast", {15'h0, rows[r].mode[3]}, {15'h0, dac_fast_acq});
    end
    // First loop step for reference codes 1 to 5 and two attack codes
    foreach (st_mode[s]) begin
      first_step(st_mode[s], st_att[s], 1'b0);
      cmp("step_gain", {1'b0, st_exp[s]}, {1'b0, g});
      cmp("step_report", {9'h000, st_exp[s][14:8]}, {8'h00, attenuation_report});
    end
    // Reset events at zero error, weight codes low, middle and high
    amp = 24'h242800;
    for (int w = 0; w < 8; w += 3) begin
      first_step({1'b0, (w == 6) ? 3'h7 : w[2:0], 4'h5}, 8'hF0, 1'b1);
      cmp("rst_weight", 16'h0008 << (w == 6 ? 7 : w), {1'b0, g});
      pulse(out_strobe, 1);
      cmp("rst_count", 16'h0001, {8'h00, rst_count});
      cmp("ovl_count", 16'h0002, {8'h00, ovl_count});
    end
    // Saturation up and down, digital gain off then on with a slow sample stream
    for (int dg = 0; dg < 2; dg++) begin
      slow = dg[0];
      amp = 24'h400000;
      do_reset();
      wr(AGC_ADDR_LOOP, 8'hF2);
      wr(AGC_ADDR_MODE, {dg[0], 7'h05});
      repeat (40) wait_tick();
      cyc(3);
      cmp("sat_vga", 16'h00FF, {8'h00, vga_dac_code});
      cmp("sat_report", dg ? 16'h007F : 16'h003F, {8'h00, attenuation_report});
      if (dg == 0) cmp("strength", 16'h000F, {10'h000, strength});
      amp = 24'h000000;
      if (dg == 0) begin
        wait_tick();
        wait_tick();
        cyc(1);
        rd(AGC_ADDR_GAIN_HI, h);
        rd(AGC_ADDR_GAIN_LO, l);
        cmp("decay_step", 16'h3B7A, {1'b0, h[6:0], l});
      end
      repeat (40) wait_tick();
      cyc(3);
      cmp("low_vga", 16'h0000, {8'h00, vga_dac_code});
      cmp("low_backoff", dg ? 16'h0000 : 16'h3FFF, {2'h0, dg_backoff});
      cmp("low_shift", dg ? 16'h0002 : 16'h0000, {14'h0, dg_shift});
    end
    print_verdict();
  end
endmodule : tb_automatic_gain_control_loop
